// ---- dv/pwg_gate_drv.sv ----
/*
 * Behavioural half-bridge gate driver on the two pulse outputs.
 * Assumes the driver shares clock_in and rst_in with the generator.
 */
`timescale 1ns/1ps

module pwg_gate_drv (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [1:0] gate_in,
	input wire logic trip_in,
	input wire logic clear_in,
	output logic fault_out,
	output logic shoot_out
);
	// Overcurrent trip reported one cycle late, as a real comparator would
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			fault_out <= 1'b0;
		end else begin
			fault_out <= trip_in;
		end
	end

	// Sticky: both switches on at once would short the supply
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			shoot_out <= 1'b0;
		end else if (clear_in) begin
			shoot_out <= 1'b0;
		end else if (gate_in === 2'b11) begin
			shoot_out <= 1'b1;
		end
	end
endmodule : pwg_gate_drv

// ---- dv/tb_pwg_top.sv ----
/*
 * Self-checking bench: register bus tasks, one task per scenario.
 * Assumes pwg_top and the gate driver model compiled before it.
 */
`timescale 1ns/1ps
`include "pwg_consts.svh"

module tb_pwg_top import pwg_pkg::*; ;
	logic clock_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] addr = 8'h00;
	logic rd = 1'b0;
	logic wr_q = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] be = 4'hF;
	logic trip = 1'b0;
	logic stall = 1'b0;
	logic sclr = 1'b0;
	logic [31:0] rdata;
	logic waitreq;
	logic [1:0] pwm;
	logic irq;
	logic trig;
	logic fault;
	logic shoot;
	int miscompares = 0;
	int checks_done = 0;
	int cyc = 0;

	always #10 clock_in = ~clock_in;
	always @(posedge clock_in) cyc <= cyc + 1;

	pwg_top i_dut (.clock_in(clock_in), .rst_in(rst_in), .avs_address_in(addr),
		.avs_read_in(rd), .avs_write_in(wr_q), .avs_writedata_in(wdata),
		.avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
		.fault_in(fault), .dbg_stall_in(stall), .pwm_out(pwm), .irq_out(irq),
		.trig_out(trig));
	pwg_gate_drv i_drv (.clock_in(clock_in), .rst_in(rst_in), .gate_in(pwm),
		.trip_in(trip), .clear_in(sclr), .fault_out(fault), .shoot_out(shoot));

	task complete_run;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task tmo(input string nm);
		miscompares++;
		$display("mismatch %s expected event seen none", nm);
		complete_run();
	endtask : tmo

	// Request held until waitrequest is sampled low
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b,
		output logic [31:0] q);
		int n;
		@(posedge clock_in);
		addr <= a;
		wdata <= d;
		be <= b;
		rd <= !w;
		wr_q <= w;
		for (n = 0; n < 50; n++) begin
			@(posedge clock_in);
			if (waitreq === 1'b0) break;
		end
		if (n == 50) tmo("waitrequest");
		q = rdata;
		rd <= 1'b0;
		wr_q <= 1'b0;
	endtask : bus

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] t;
		bus(1'b1, a, d, 4'hF, t);
	endtask : wr

	task rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, 4'hF, q);
		chk(nm, exp, q);
	endtask : rc

	function automatic logic [31:0] ac(input int ev, input pwg_act_t a);
		return {30'h0, a} << (2 * ev);
	endfunction : ac

	task wp(input logic tr, output int t);
		int n;
		for (n = 0; n < 300; n++) begin
			@(posedge clock_in);
			if ((tr ? trig : irq) === 1'b1) break;
		end
		if (n == 300) tmo("pulse");
		t = cyc;
	endtask : wp

	task gap(input logic f, input logic s, input int exp, input string nm);
		int t1;
		int t2;
		wp(f, t1);
		wp(s, t2);
		chk(nm, exp, t2 - t1);
	endtask : gap

	task wt(input int n, output int ha, output int hb, output int ea, output int eb);
		logic [1:0] p;
		ha = 0;
		hb = 0;
		ea = 0;
		eb = 0;
		p = pwm;
		repeat (n) begin
			@(posedge clock_in);
			ha += (pwm[0] === 1'b1);
			hb += (pwm[1] === 1'b1);
			ea += (pwm[0] !== p[0]);
			eb += (pwm[1] !== p[1]);
			p = pwm;
		end
	endtask : wt

	task wpwm(input logic [1:0] exp);
		int n;
		for (n = 0; n < 30; n++) begin
			@(posedge clock_in);
			if (pwm === exp) break;
		end
		chk("pwm_out", exp, pwm);
	endtask : wpwm

	// Stop, zero the counter, set the period, run and let it settle
	task rs(input logic [31:0] ld, input logic [31:0] gc);
		wr(`PWG_OFS_GCTL, 32'h0);
		wr(`PWG_OFS_SYNC, 32'h1);
		wr(`PWG_OFS_LOAD, ld);
		wr(`PWG_OFS_GCTL, gc);
		repeat (60) @(posedge clock_in);
	endtask : rs

	task sc_reset;
		logic [31:0] q;
		@(posedge clock_in);
		chk("pwm_out", 32'h0, pwm);
		chk("irq_out", 32'h0, irq);
		chk("waitrequest", 32'h1, waitreq);
		for (int a = 0; a < 8'h80; a += 4) rc("reset value", a[7:0], 32'h0);
		wr(`PWG_OFS_LOAD, 32'h1234);
		bus(1'b1, `PWG_OFS_LOAD, 32'hFFFF_FFFF, 4'h1, q);
		rc("load lanes", `PWG_OFS_LOAD, 32'h12FF);
		rc("misaligned", `PWG_OFS_LOAD + 8'h01, 32'h0);
		wr(`PWG_OFS_COUNT, 32'h5);
		rc("count ro", `PWG_OFS_COUNT, 32'h0);
		rc("unmapped", 8'h80, 32'h0);
	endtask : sc_reset

	task sc_count;
		wr(`PWG_OFS_EVSEL, 32'h0102);
		rs(32'h3, 32'h1);
		gap(1'b1, 1'b1, 4, "down period");
		gap(1'b1, 1'b0, 1, "load after zero");
		wr(`PWG_OFS_CMPA, 32'h1);
		rs(32'h4, 32'h3);
		gap(1'b1, 1'b1, 8, "updown period");
		gap(1'b1, 1'b0, 4, "zero to load");
		wr(`PWG_OFS_EVSEL, 32'h0804);
		gap(1'b0, 1'b1, 6, "a up to a down");
	endtask : sc_count

	task sc_gen;
		int ha;
		int hb;
		int ea;
		int eb;
		wr(`PWG_OFS_ENABLE, 32'h3);
		wr(`PWG_OFS_CMPA, 32'h5);
		wr(`PWG_OFS_CMPB, 32'h2);
		wr(`PWG_OFS_ACTA, ac(`PWG_EV_ZERO, ACT_HIGH) | ac(`PWG_EV_ADN, ACT_LOW));
		wr(`PWG_OFS_ACTB, ac(`PWG_EV_ZERO, ACT_HIGH) | ac(`PWG_EV_BDN, ACT_LOW));
		rs(32'h9, 32'h1);
		wt(20, ha, hb, ea, eb);
		chk("a high", 32'd10, ha);
		chk("b high", 32'd16, hb);
		wr(`PWG_OFS_CMPB, 32'h5);
		wr(`PWG_OFS_ACTA, ac(`PWG_EV_ADN, ACT_HIGH) | ac(`PWG_EV_BDN, ACT_LOW));
		wr(`PWG_OFS_ACTB, ac(`PWG_EV_BDN, ACT_HIGH) | ac(`PWG_EV_ADN, ACT_LOW));
		repeat (25) @(posedge clock_in);
		wt(20, ha, hb, ea, eb);
		chk("a coincide", 32'd20, ha);
		chk("b coincide", 32'd20, hb);
		wr(`PWG_OFS_CMPA, 32'hC);
		wr(`PWG_OFS_CMPB, 32'h0);
		wr(`PWG_OFS_ACTA, ac(`PWG_EV_ADN, ACT_TOGGLE));
		wr(`PWG_OFS_ACTB, ac(`PWG_EV_BDN, ACT_TOGGLE));
		repeat (25) @(posedge clock_in);
		wt(30, ha, hb, ea, eb);
		chk("a above load", 32'd0, ea);
		chk("b on zero", 32'd0, eb);
		wr(`PWG_OFS_CMPA, 32'h5);
		repeat (25) @(posedge clock_in);
		wt(20, ha, hb, ea, eb);
		chk("a toggles", 32'd2, ea);
	endtask : sc_gen

	task sc_dead;
		int ha;
		int hb;
		int ea;
		int eb;
		wr(`PWG_OFS_ACTA, ac(`PWG_EV_ZERO, ACT_HIGH) | ac(`PWG_EV_ADN, ACT_LOW));
		wr(`PWG_OFS_ACTB, ac(`PWG_EV_ZERO, ACT_HIGH));
		wr(`PWG_OFS_DBRISE, 32'h2);
		wr(`PWG_OFS_DBFALL, 32'h3);
		wr(`PWG_OFS_DBCTL, 32'h1);
		wr(`PWG_OFS_EVSEL, 32'h0801);
		rs(32'd19, 32'h1);
		@(posedge clock_in);
		sclr <= 1'b1;
		@(posedge clock_in);
		sclr <= 1'b0;
		wt(40, ha, hb, ea, eb);
		chk("db a high", 32'd26, ha);
		chk("db b high", 32'd4, hb);
		chk("overlap", 32'h0, shoot);
		gap(1'b0, 1'b1, 15, "raw events");
		wr(`PWG_OFS_DBCTL, 32'h0);
	endtask : sc_dead

	task sc_out;
		int t;
		wr(`PWG_OFS_EVSEL, 32'h0);
		wr(`PWG_OFS_ACTB, ac(`PWG_EV_ZERO, ACT_LOW));
		wr(`PWG_OFS_ACTA, ac(`PWG_EV_ZERO, ACT_HIGH));
		wpwm(2'b01);
		wr(`PWG_OFS_ENABLE, 32'h2);
		wpwm(2'b00);
		wr(`PWG_OFS_ENABLE, 32'h3);
		wr(`PWG_OFS_INVERT, 32'h2);
		wpwm(2'b11);
		wr(`PWG_OFS_FAULT, 32'h1);
		wr(`PWG_OFS_FINTEN, 32'h1);
		@(posedge clock_in);
		trip <= 1'b1;
		wp(1'b0, t);
		wpwm(2'b10);
		rc("status", `PWG_OFS_STATUS, 32'h1);
		@(posedge clock_in);
		trip <= 1'b0;
		wpwm(2'b11);
	endtask : sc_out

	task sc_sync;
		wr(`PWG_OFS_EVSEL, 32'h0100);
		rs(32'h3, 32'h1);
		wr(`PWG_OFS_GCTL, 32'h9);
		gap(1'b1, 1'b1, 4, "old period");
		wr(`PWG_OFS_LOAD, 32'h7);
		repeat (30) @(posedge clock_in);
		gap(1'b1, 1'b1, 4, "pending period");
		wr(`PWG_OFS_MCTL, 32'h1);
		repeat (30) @(posedge clock_in);
		gap(1'b1, 1'b1, 8, "new period");
		rc("update done", `PWG_OFS_MCTL, 32'h0);
	endtask : sc_sync

	task sc_stall;
		logic [31:0] q1;
		logic [31:0] q2;
		int n;
		wr(`PWG_OFS_EVSEL, 32'h0);
		rs(32'd99, 32'h1);
		@(posedge clock_in);
		stall <= 1'b1;
		n = 0;
		repeat (150) begin
			@(posedge clock_in);
			n += (irq === 1'b1);
		end
		chk("stall irq", 32'h0, n);
		rc("stopped", `PWG_OFS_COUNT, 32'h0);
		rc("still stopped", `PWG_OFS_COUNT, 32'h0);
		wr(`PWG_OFS_GCTL, 32'h5);
		bus(1'b0, `PWG_OFS_COUNT, 32'h0, 4'hF, q1);
		bus(1'b0, `PWG_OFS_COUNT, 32'h0, 4'hF, q2);
		chk("runs in stall", 32'h1, q1 !== q2);
		stall <= 1'b0;
		wr(`PWG_OFS_GCTL, 32'h0);
		wr(`PWG_OFS_SYNC, 32'h1);
		rc("sync reset", `PWG_OFS_COUNT, 32'h0);
		rc("sync clear", `PWG_OFS_SYNC, 32'h0);
	endtask : sc_stall

	initial begin
		repeat (2) @(posedge clock_in);
		rst_in <= 1'b0;
		sc_reset();
		sc_count();
		sc_gen();
		sc_dead();
		sc_out();
		sc_sync();
		sc_stall();
		complete_run();
	end
endmodule : tb_pwg_top

// ---- logic/pwg_consts.svh ----
/*
 * Register map, field positions, reset values and widths of the pulse-width generator.
 * Assumes byte addressing on the register bus with one aligned 32-bit word per register.
 */
`ifndef PWG_CONSTS_SVH
`define PWG_CONSTS_SVH

`define PWG_ADDR_W 8
`define PWG_CNT_W 16
`define PWG_DB_W 12
`define PWG_NUM_EV 6

`define PWG_OFS_MCTL 8'h00
`define PWG_OFS_SYNC 8'h04
`define PWG_OFS_ENABLE 8'h08
`define PWG_OFS_INVERT 8'h0C
`define PWG_OFS_FAULT 8'h10
`define PWG_OFS_FINTEN 8'h14
`define PWG_OFS_STATUS 8'h20
`define PWG_OFS_GCTL 8'h40
`define PWG_OFS_EVSEL 8'h44
`define PWG_OFS_LOAD 8'h50
`define PWG_OFS_COUNT 8'h54
`define PWG_OFS_CMPA 8'h58
`define PWG_OFS_CMPB 8'h5C
`define PWG_OFS_ACTA 8'h60
`define PWG_OFS_ACTB 8'h64
`define PWG_OFS_DBCTL 8'h68
`define PWG_OFS_DBRISE 8'h6C
`define PWG_OFS_DBFALL 8'h70

`define PWG_GCTL_RUN 0
`define PWG_GCTL_UPDOWN 1
`define PWG_GCTL_DBGRUN 2
`define PWG_GCTL_SYNCUPD 3
`define PWG_GCTL_W 4

`define PWG_EV_ZERO 0
`define PWG_EV_LOAD 1
`define PWG_EV_AUP 2
`define PWG_EV_ADN 3
`define PWG_EV_BUP 4
`define PWG_EV_BDN 5
`define PWG_EVSEL_TRIG 8

`define PWG_RST_WORD 32'h0000_0000
`define PWG_RST_CNT 16'h0000
`define PWG_RST_DB 12'h000

`endif

// ---- logic/pwg_pkg.sv ----
/*
 * Types of the pulse-width generator.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pwg_pkg;

	// Per-event output action, two bits each
	typedef enum logic [1:0] {
		ACT_KEEP,
		ACT_TOGGLE,
		ACT_LOW,
		ACT_HIGH
	} pwg_act_t;

endpackage : pwg_pkg

// ---- logic/pwg_top.sv ----
/*
 * Pulse-width generator with counter, two comparators, action generator, dead-band pair,
 * event selector for interrupt and converter trigger, fault masking and output control.
 * Assumes an Avalon-MM master on clock_in; fault_in and dbg_stall_in are asynchronous pins.
 */
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
// Contract
// (RULE1) One 16-bit counter, counting down or up/down.
// (RULE2) Down mode: load value to zero, reload, repeat.
// (RULE3) Up/down mode: zero up to load, back to zero, repeat.
// (RULE4) Direction low in down mode, follows count direction in up/down mode.
// (RULE5) One-cycle pulses at zero and at load; load follows zero in down mode.
// (RULE6) Compare match pulses, split by direction into up and down events in up/down.
// (RULE7) Match value above load value never matches.
// (RULE8) Four events in down mode, six in up/down mode.
// (RULE9) Matches coinciding with zero or load are ignored by the generator.
// (RULE10) Coinciding A and B matches: output A sees A only, output B sees B only.
// (RULE11) Each event sets keep, toggle, low or high per output.
// (RULE12) Dead-band disabled: both generator outputs pass unchanged.
// (RULE13) Dead-band enabled: output A is input with rising edge delayed; B discarded.
// (RULE14) Output B is inverted input, rising a fall delay after input falls.
// (RULE15) Interrupt on selected events; trigger pulse on a separate selection.
// (RULE16) Interrupt and trigger use raw counter events, not dead-band outputs.
// (RULE17) Global synchronous reset returns selected counters to zero.
// (RULE18) Immediate mode: new load and compare take effect at next zero.
// (RULE19) Sync mode: new values wait for global update, then apply at zero.
// (RULE20) Fault forces enabled outputs inactive; fault may raise interrupt.
// (RULE21) Debug stall: keep running or stop at zero; no interrupt.
// (RULE22) Outputs gated by one enable mask, then optional per-output inversion.
// (RULE23) Action code: 00 keep, 01 toggle, 10 low, 11 high.
// (RULE24) Dead-band delays counted in clock cycles by a reloading down counter.
`timescale 1ns/1ps
`include "pwg_consts.svh"

module pwg_top import pwg_pkg::*; (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [`PWG_ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic fault_in,
	input wire logic dbg_stall_in,
	output logic [1:0] pwm_out,
	output logic irq_out,
	output logic trig_out
);

	function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
			input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction : be_merge

	function automatic logic apply_act(input logic cur, input pwg_act_t act);
		logic r;
		r = cur;
		unique case (act)
			ACT_KEEP: r = cur;
			ACT_TOGGLE: r = ~cur;
			ACT_LOW: r = 1'b0;
			ACT_HIGH: r = 1'b1;
		endcase
		return r;
	endfunction : apply_act

	// Later events in the vector override earlier ones
	function automatic logic gen_step(input logic cur, input logic [`PWG_NUM_EV-1:0] ev,
			input logic [2*`PWG_NUM_EV-1:0] acts);
		logic r;
		r = cur;
		for (int i = 0; i < `PWG_NUM_EV; i++) begin
			if (ev[i]) begin
				r = apply_act(r, pwg_act_t'(acts[2*i +: 2])); // RULE11 RULE23
			end
		end
		return r;
	endfunction : gen_step

	logic wait_q;
	logic [31:0] rdata_q;
	logic [31:0] rd_val;
	logic [31:0] wval;
	logic wr_en;
	logic gsync_q;
	logic cnt_rst_q;
	logic [1:0] enable_q;
	logic [1:0] invert_q;
	logic [1:0] fault_en_q;
	logic fault_ien_q;
	logic [`PWG_GCTL_W-1:0] gctl_q;
	logic [`PWG_NUM_EV-1:0] isel_q;
	logic [`PWG_NUM_EV-1:0] tsel_q;
	logic [`PWG_CNT_W-1:0] load_q;
	logic [`PWG_CNT_W-1:0] cmpa_q;
	logic [`PWG_CNT_W-1:0] cmpb_q;
	logic [2*`PWG_NUM_EV-1:0] act_a_q;
	logic [2*`PWG_NUM_EV-1:0] act_b_q;
	logic db_en_q;
	logic [`PWG_DB_W-1:0] db_rise_q;
	logic [`PWG_DB_W-1:0] db_fall_q;

	assign wr_en = avs_write_in & ~wait_q;
	assign avs_waitrequest_out = wait_q;
	assign avs_readdata_out = rdata_q;

	// Bus handshake: one wait cycle, then a single ready cycle
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= ~((avs_read_in | avs_write_in) & wait_q);
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_q <= `PWG_RST_WORD;
		end else if (avs_read_in & wait_q) begin
			rdata_q <= rd_val;
		end
	end

	logic fault_m_q;
	logic fault_s_q;
	logic fault_d_q;
	logic stall_m_q;
	logic stall_s_q;
	logic [`PWG_CNT_W-1:0] cnt_q;
	logic dir_q;
	logic [`PWG_CNT_W-1:0] load_a_q;
	logic [`PWG_CNT_W-1:0] cmpa_a_q;
	logic [`PWG_CNT_W-1:0] cmpb_a_q;

	always_comb begin
		rd_val = `PWG_RST_WORD;
		case (avs_address_in)
			`PWG_OFS_MCTL: rd_val[0] = gsync_q;
			`PWG_OFS_SYNC: rd_val[0] = cnt_rst_q;
			`PWG_OFS_ENABLE: rd_val[1:0] = enable_q;
			`PWG_OFS_INVERT: rd_val[1:0] = invert_q;
			`PWG_OFS_FAULT: rd_val[1:0] = fault_en_q;
			`PWG_OFS_FINTEN: rd_val[0] = fault_ien_q;
			`PWG_OFS_STATUS: rd_val[0] = fault_s_q;
			`PWG_OFS_GCTL: rd_val[`PWG_GCTL_W-1:0] = gctl_q;
			`PWG_OFS_EVSEL: begin
				rd_val[`PWG_NUM_EV-1:0] = isel_q;
				rd_val[`PWG_EVSEL_TRIG +: `PWG_NUM_EV] = tsel_q;
			end
			`PWG_OFS_LOAD: rd_val[`PWG_CNT_W-1:0] = load_q;
			`PWG_OFS_COUNT: rd_val[`PWG_CNT_W-1:0] = cnt_q;
			`PWG_OFS_CMPA: rd_val[`PWG_CNT_W-1:0] = cmpa_q;
			`PWG_OFS_CMPB: rd_val[`PWG_CNT_W-1:0] = cmpb_q;
			`PWG_OFS_ACTA: rd_val[2*`PWG_NUM_EV-1:0] = act_a_q;
			`PWG_OFS_ACTB: rd_val[2*`PWG_NUM_EV-1:0] = act_b_q;
			`PWG_OFS_DBCTL: rd_val[0] = db_en_q;
			`PWG_OFS_DBRISE: rd_val[`PWG_DB_W-1:0] = db_rise_q;
			`PWG_OFS_DBFALL: rd_val[`PWG_DB_W-1:0] = db_fall_q;
			default: rd_val = `PWG_RST_WORD;
		endcase
		wval = be_merge(rd_val, avs_writedata_in, avs_byteenable_in);
	end

	// Plain configuration registers
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			enable_q <= 2'h0;
			invert_q <= 2'h0;
			fault_en_q <= 2'h0;
			fault_ien_q <= 1'b0;
			gctl_q <= '0;
			isel_q <= '0;
			tsel_q <= '0;
			load_q <= `PWG_RST_CNT;
			cmpa_q <= `PWG_RST_CNT;
			cmpb_q <= `PWG_RST_CNT;
			act_a_q <= '0;
			act_b_q <= '0;
			db_en_q <= 1'b0;
			db_rise_q <= `PWG_RST_DB;
			db_fall_q <= `PWG_RST_DB;
		end else if (wr_en) begin
			case (avs_address_in)
				`PWG_OFS_ENABLE: enable_q <= wval[1:0];
				`PWG_OFS_INVERT: invert_q <= wval[1:0];
				`PWG_OFS_FAULT: fault_en_q <= wval[1:0];
				`PWG_OFS_FINTEN: fault_ien_q <= wval[0];
				`PWG_OFS_GCTL: gctl_q <= wval[`PWG_GCTL_W-1:0];
				`PWG_OFS_EVSEL: begin
					isel_q <= wval[`PWG_NUM_EV-1:0];
					tsel_q <= wval[`PWG_EVSEL_TRIG +: `PWG_NUM_EV];
				end
				`PWG_OFS_LOAD: load_q <= wval[`PWG_CNT_W-1:0];
				`PWG_OFS_CMPA: cmpa_q <= wval[`PWG_CNT_W-1:0];
				`PWG_OFS_CMPB: cmpb_q <= wval[`PWG_CNT_W-1:0];
				`PWG_OFS_ACTA: act_a_q <= wval[2*`PWG_NUM_EV-1:0];
				`PWG_OFS_ACTB: act_b_q <= wval[2*`PWG_NUM_EV-1:0];
				`PWG_OFS_DBCTL: db_en_q <= wval[0];
				`PWG_OFS_DBRISE: db_rise_q <= wval[`PWG_DB_W-1:0];
				`PWG_OFS_DBFALL: db_fall_q <= wval[`PWG_DB_W-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			fault_m_q <= 1'b0;
			fault_s_q <= 1'b0;
			fault_d_q <= 1'b0;
			stall_m_q <= 1'b0;
			stall_s_q <= 1'b0;
		end else begin
			fault_m_q <= fault_in;
			fault_s_q <= fault_m_q;
			fault_d_q <= fault_s_q;
			stall_m_q <= dbg_stall_in;
			stall_s_q <= stall_m_q;
		end
	end

	logic cnt_zero;
	logic running;
	logic counting;
	logic upd_now;
	logic [`PWG_CNT_W-1:0] ld_next;

	assign cnt_zero = (cnt_q == `PWG_RST_CNT);
	assign running = gctl_q[`PWG_GCTL_RUN] &
		~(stall_s_q & ~gctl_q[`PWG_GCTL_DBGRUN] & cnt_zero); // RULE21
	assign counting = running & ~cnt_rst_q;
	assign upd_now = counting & cnt_zero & (~gctl_q[`PWG_GCTL_SYNCUPD] | gsync_q); // RULE18 RULE19
	assign ld_next = upd_now ? load_q : load_a_q;

	// Global update request: software sets, clears once applied; set wins
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			gsync_q <= 1'b0;
		end else if (wr_en && avs_address_in == `PWG_OFS_MCTL && wval[0]) begin
			gsync_q <= 1'b1;
		end else if (upd_now) begin
			gsync_q <= 1'b0; // RULE19
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_rst_q <= 1'b0;
		end else if (wr_en && avs_address_in == `PWG_OFS_SYNC && wval[0]) begin
			cnt_rst_q <= 1'b1;
		end else begin
			cnt_rst_q <= 1'b0;
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			load_a_q <= `PWG_RST_CNT;
			cmpa_a_q <= `PWG_RST_CNT;
			cmpb_a_q <= `PWG_RST_CNT;
		end else if (upd_now) begin
			load_a_q <= load_q; // RULE18 RULE19
			cmpa_a_q <= cmpa_q;
			cmpb_a_q <= cmpb_q;
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_q <= `PWG_RST_CNT;
			dir_q <= 1'b0;
		end else if (cnt_rst_q) begin
			cnt_q <= `PWG_RST_CNT; // RULE17
			dir_q <= 1'b0;
		end else if (running) begin
			if (!gctl_q[`PWG_GCTL_UPDOWN]) begin
				dir_q <= 1'b0; // RULE4
				cnt_q <= cnt_zero ? ld_next : cnt_q - 16'h0001; // RULE1 RULE2
			end else if (dir_q) begin
				if (cnt_q >= ld_next) begin
					dir_q <= 1'b0; // RULE3 RULE4
					cnt_q <= cnt_zero ? cnt_q : cnt_q - 16'h0001;
				end else begin
					cnt_q <= cnt_q + 16'h0001;
				end
			end else if (cnt_zero) begin
				dir_q <= 1'b1; // RULE3
				cnt_q <= (ld_next == `PWG_RST_CNT) ? cnt_q : 16'h0001;
			end else begin
				cnt_q <= cnt_q - 16'h0001;
			end
		end
	end

	logic a_hit;
	logic b_hit;
	logic [`PWG_NUM_EV-1:0] ev;
	logic [`PWG_NUM_EV-1:0] ev_a;
	logic [`PWG_NUM_EV-1:0] ev_b;

	assign a_hit = counting & (cnt_q == cmpa_a_q) & (cmpa_a_q <= load_a_q); // RULE6 RULE7
	assign b_hit = counting & (cnt_q == cmpb_a_q) & (cmpb_a_q <= load_a_q); // RULE6 RULE7

	always_comb begin
		ev = '0;
		ev[`PWG_EV_ZERO] = counting & cnt_zero; // RULE5
		ev[`PWG_EV_LOAD] = counting & (cnt_q == load_a_q); // RULE5
		ev[`PWG_EV_AUP] = a_hit & dir_q; // RULE6 RULE8
		ev[`PWG_EV_ADN] = a_hit & ~dir_q;
		ev[`PWG_EV_BUP] = b_hit & dir_q;
		ev[`PWG_EV_BDN] = b_hit & ~dir_q;
		ev_a = ev;
		ev_b = ev;
		if (ev[`PWG_EV_ZERO] | ev[`PWG_EV_LOAD]) begin
			ev_a[`PWG_EV_BDN:`PWG_EV_AUP] = 4'h0; // RULE9
			ev_b[`PWG_EV_BDN:`PWG_EV_AUP] = 4'h0;
		end
		if (a_hit) begin
			ev_a[`PWG_EV_BDN:`PWG_EV_BUP] = 2'h0; // RULE10
		end
		if (b_hit) begin
			ev_b[`PWG_EV_ADN:`PWG_EV_AUP] = 2'h0; // RULE10
		end
	end

	logic gen_a_q;
	logic gen_b_q;

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			gen_a_q <= 1'b0;
			gen_b_q <= 1'b0;
		end else begin
			gen_a_q <= gen_step(gen_a_q, ev_a, act_a_q); // RULE11
			gen_b_q <= gen_step(gen_b_q, ev_b, act_b_q); // RULE11
		end
	end

	logic db_prev_q;
	logic db_a_q;
	logic db_b_q;
	logic [`PWG_DB_W-1:0] db_cnt_q;
	logic [`PWG_DB_W-1:0] db_load;
	logic db_now;

	assign db_load = gen_a_q ? db_rise_q : db_fall_q;
	assign db_now = (db_load == `PWG_RST_DB);

	// Both outputs low while a delay runs; the edge cycle is the first delay cycle
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			db_prev_q <= 1'b0;
			db_a_q <= 1'b0;
			db_b_q <= 1'b0;
			db_cnt_q <= `PWG_RST_DB;
		end else begin
			db_prev_q <= gen_a_q;
			if (gen_a_q != db_prev_q) begin
				db_cnt_q <= db_now ? `PWG_RST_DB : db_load - 12'h001; // RULE24
				db_a_q <= db_now & gen_a_q;
				db_b_q <= db_now & ~gen_a_q;
			end else if (db_cnt_q != `PWG_RST_DB) begin
				db_cnt_q <= db_cnt_q - 12'h001; // RULE24
			end else begin
				db_a_q <= gen_a_q; // RULE13
				db_b_q <= ~gen_a_q; // RULE14
			end
		end
	end

	logic [1:0] raw;
	logic [1:0] fault_mask;

	assign raw = db_en_q ? {db_b_q, db_a_q} : {gen_b_q, gen_a_q}; // RULE12 RULE13
	assign fault_mask = {2{fault_s_q}} & fault_en_q;

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			pwm_out <= 2'h0;
		end else begin
			pwm_out <= ((raw & ~fault_mask) & enable_q) ^ invert_q; // RULE20 RULE22
		end
	end

	// Raw events and fault onset only; stall never feeds the interrupt
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			irq_out <= 1'b0;
			trig_out <= 1'b0;
		end else begin
			irq_out <= (|(ev & isel_q)) | (fault_ien_q & fault_s_q & ~fault_d_q); // RULE15 RULE16 RULE20
			trig_out <= |(ev & tsel_q); // RULE15 RULE16
		end
	end

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);

	down_reload_a: assert property (counting && !gctl_q[`PWG_GCTL_UPDOWN] && cnt_zero // RULE2
		|=> cnt_q == $past(ld_next))
		else $error("down counter did not reload at zero");
	down_step_a: assert property (counting && !gctl_q[`PWG_GCTL_UPDOWN] && !cnt_zero // RULE2
		|=> cnt_q == $past(cnt_q) - 16'h0001)
		else $error("down counter did not decrement");
	dir_down_a: assert property (running && !gctl_q[`PWG_GCTL_UPDOWN] |=> !dir_q) // RULE4
		else $error("direction high in down mode");
	up_turn_a: assert property (counting && gctl_q[`PWG_GCTL_UPDOWN] && dir_q // RULE3
		&& cnt_q < ld_next |=> cnt_q == $past(cnt_q) + 16'h0001 && dir_q)
		else $error("up/down counter failed to count up");
	cmp_over_a: assert property (cmpa_a_q > load_a_q |-> !a_hit) // RULE7
		else $error("match above load value");
	hold_mid_a: assert property (!cnt_zero |=> $stable(load_a_q) && $stable(cmpa_a_q)) // RULE18
		else $error("active value changed mid-period");
	sync_wait_a: assert property (gctl_q[`PWG_GCTL_SYNCUPD] && !gsync_q // RULE19
		|=> $stable(load_a_q) && $stable(cmpb_a_q))
		else $error("pending value applied without global update");
	pass_thru_a: assert property (!db_en_q && !fault_s_q && enable_q == 2'h3 // RULE12
		&& invert_q == 2'h0 |=> pwm_out == $past({gen_b_q, gen_a_q}))
		else $error("disabled dead-band altered outputs");
	db_gap_a: assert property (db_en_q |-> !(db_a_q && db_b_q)) // RULE14
		else $error("dead-band outputs high together");
	fault_force_a: assert property (fault_s_q && fault_en_q[0] // RULE20
		|=> pwm_out[0] == $past(invert_q[0]))
		else $error("faulted output not inactive");
	stall_stop_a: assert property (gctl_q[`PWG_GCTL_RUN] && stall_s_q && cnt_zero // RULE21
		&& !gctl_q[`PWG_GCTL_DBGRUN] && !cnt_rst_q |=> cnt_zero)
		else $error("counter moved during stall at zero");
	irq_event_a: assert property (|(ev & isel_q) |=> irq_out) // RULE15
		else $error("selected event raised no interrupt");

endmodule : pwg_top
